// *** bench/fswp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Host controller model, serial mode 0.
// ********
module fswp_host (
	output logic spi_clk_o,
	output logic cs_n_o,
	output logic mosi_o,
	input wire logic miso_i
);
	initial
	begin
		spi_clk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic xfer(input logic [39:0] d, input int nb, output logic [7:0] rd);
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < nb; i++)
		begin
			mosi_o = d[39 - i];
			#32 spi_clk_o = 1'b1;
			rd = {rd[6:0], miso_i};
			#32 spi_clk_o = 1'b0;
		end
		#32 cs_n_o = 1'b1;
		// A released data line must not keep looking like the last bit.
		mosi_o = ~mosi_o;
		#160;
	endtask
endmodule
`default_nettype wire

// *** bench/fswp_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Port checker.
// ********
module fswp_monitor #(
	parameter logic [23:0] PUW_CYCLES = 24'h030D40
) (
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	input wire logic cs_n_i,
	input wire logic busy_o,
	input wire logic op_start_o,
	input wire logic [2:0] op_kind_o,
	input wire logic [2:0] sec_lock_o,
	input wire logic quad_enable_o,
	input wire logic hold_func_o,
	input wire logic reset_func_o,
	input wire logic deep_pd_o,
	input wire logic suspended_o
);
	// Saturating, so a long run never wraps back into the delay window.
	logic [23:0] up_cnt;
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
		if (!arst_n_i)
			up_cnt <= 24'h0;
		else if (up_cnt < PUW_CYCLES)
			up_cnt <= up_cnt + 24'h1;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	a_start_after_delay: assert property (op_start_o |-> up_cnt == PUW_CYCLES)
		else $error("Operation started inside the power-up delay");
	a_start_not_dpd: assert property (deep_pd_o |-> !op_start_o)
		else $error("Operation started in deep power-down");
	a_start_not_busy: assert property ($past(busy_o) |-> !op_start_o)
		else $error("Operation started while busy");
	a_start_kind_legal: assert property (op_start_o |-> op_kind_o inside {[3'h1:3'h6]} ##1 !op_start_o)
		else $error("Bad operation kind or long start pulse");
	a_start_frame_over: assert property (op_start_o |-> cs_n_i && $past(cs_n_i, 2))
		else $error("Operation started inside a frame");
	a_quad_pins_off: assert property (quad_enable_o && $past(quad_enable_o) |-> !hold_func_o && !reset_func_o)
		else $error("Pin function active with quad on");
	a_pin_func_excl: assert property (!(hold_func_o && reset_func_o))
		else $error("Hold and reset functions both active");
	a_lock_never_clears: assert property ((~sec_lock_o & $past(sec_lock_o)) == 3'h0)
		else $error("Security lock bit cleared");
	a_susp_not_busy: assert property (suspended_o && $past(suspended_o) |-> !busy_o)
		else $error("Busy while suspended");
	c_start: cover property (op_start_o);
	c_susp: cover property (suspended_o);
	c_dpd: cover property (deep_pd_o);
	c_quad: cover property (quad_enable_o);
endmodule
bind fswp_core fswp_monitor #(.PUW_CYCLES(PUW_CYCLES)) u_mon (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
	.cs_n_i(cs_n_i), .busy_o(busy_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o), .sec_lock_o(sec_lock_o),
	.quad_enable_o(quad_enable_o), .hold_func_o(hold_func_o), .reset_func_o(reset_func_o),
	.deep_pd_o(deep_pd_o), .suspended_o(suspended_o));
`default_nettype wire

// *** bench/test_flash_status_write_protect.sv ***
`timescale 1ns/1ps
`include "fswp_defs.vh"
`default_nettype none
module test_flash_status_write_protect;
	logic sys_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic wp_n_i = 1'b1;
	logic hr_n_i = 1'b1;
	wire spi_clk, cs_n, mosi, miso, busy, op_start, quad, hold_f, reset_f, high_frequency_enable, deep_pd, susp;
	wire [2:0] op_kind, sec_lock;
	wire [23:0] op_addr;
	wire [1:0] drv;
	logic [7:0] rd;
	int n_fail = 0;
	int n_compared = 0;
	int n_ops = 0;
	always #2.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
		if (op_start === 1'b1)
			n_ops++;
	fswp_host host (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
	fswp_core #(.PUW_CYCLES(24'h190), .WSR_CYCLES(24'h64), .PP_CYCLES(24'h7D0), .ERASE_CYCLES(24'h7D0)) uut (
		.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .spi_clk_i(spi_clk), .cs_n_i(cs_n), .mosi_i(mosi),
		.wp_n_i(wp_n_i), .hold_reset_n_i(hr_n_i), .miso_o(miso), .miso_oe_o(), .busy_o(busy),
		.op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr), .sec_lock_o(sec_lock),
		.quad_enable_o(quad), .hold_func_o(hold_f), .reset_func_o(reset_f), .drive_strength_o(drv),
		.high_freq_o(high_frequency_enable), .deep_pd_o(deep_pd), .suspended_o(susp));
	task automatic close_out;
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tx(input logic [39:0] d, input int nb);
		host.xfer(d, nb, rd);
	endtask
	task automatic rdsr(input logic [7:0] c, input logic [7:0] e);
		host.xfer({c, 32'h0}, 16, rd);
		chk(rd, e);
	endtask
	task automatic wait_idle;
		int i;
		for (i = 0; i < 5000 && busy !== 1'b0; i++)
			@(posedge sys_clk_i);
		if (i == 5000)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, busy, 1'b0);
			close_out();
		end
	endtask
	task automatic wsr(input logic [23:0] v, input int nb);
		tx(40'h0600000000, 8);
		tx({8'h01, v, 8'h0}, nb);
		wait_idle();
	endtask
	task automatic setwp(input logic v);
		@(posedge sys_clk_i);
		#1 wp_n_i = v;
	endtask
	task automatic s_powerup;
		tx(40'h0600000000, 8);
		rdsr(8'h05, 8'h00); // Early enable refused.
		repeat (400) @(posedge sys_clk_i);
		tx(40'h0600000000, 8);
		rdsr(8'h05, 8'h02); // Latch set later.
	endtask
	task automatic s_nv;
		setwp(1'b0);
		tx(40'h0600000000, 8);
		tx(40'h0127000000, 16);
		chk(busy, 1'b1); // Busy while writing.
		wait_idle();
		setwp(1'b1);
		rdsr(8'h05, 8'h24); // Pin ignored, flags kept.
	endtask
	task automatic s_prot;
		logic [7:0] s1 [3] = '{8'h24, 8'h64, 8'h64};
		logic [7:0] s2 [3] = '{8'h00, 8'h00, 8'h40};
		logic [23:0] bad [3] = '{24'h00F000, 24'h000000, 24'h001000};
		logic [23:0] good [3] = '{24'h010000, 24'h001000, 24'h000000};
		int c;
		for (int k = 0; k < 3; k++)
		begin
			wsr({s1[k], s2[k], 8'h0}, 24);
			c = n_ops;
			tx(40'h0600000000, 8);
			tx({8'h20, bad[k], 8'h0}, 32);
			chk(n_ops, c); // Protected erase ignored.
			rdsr(8'h05, s1[k] | 8'h02); // Refusal keeps latch.
			tx({8'h20, good[k], 8'h0}, 32);
			chk(n_ops, c + 1); // Free erase accepted.
			chk({5'h0, op_kind, op_addr}, {5'h0, `FSWP_OP_SERASE, good[k]}); // Edge region erased.
			wait_idle();
		end
		wsr(24'h000000, 24);
	endtask
	task automatic s_srp;
		wsr(24'h800000, 16);
		setwp(1'b0);
		wsr(24'h840000, 16);
		rdsr(8'h05, 8'h82); // Pin low locks.
		setwp(1'b1);
		wsr(24'h840000, 16);
		rdsr(8'h05, 8'h84); // Pin high unlocks.
		wsr(24'h000000, 16);
	endtask
	task automatic s_vol;
		for (int d = 0; d < 4; d++)
		begin
			tx(40'h5000000000, 8);
			tx({8'h01, 16'h0, 1'b0, d[1:0], 5'h0, 8'h0}, 32);
			chk(drv, d); // Drive field follows.
		end
		tx(40'h5000000000, 8);
		tx(40'h01003A0000, 24);
		chk({sec_lock, quad, hold_f, reset_f}, 6'h04); // Locks kept, pins off.
		tx(40'h5000000000, 8);
		tx(40'h0100009000, 32);
		chk({quad, hold_f, reset_f, high_frequency_enable}, 4'h3); // Reset function chosen.
		tx(40'h0600000000, 8);
		@(posedge sys_clk_i);
		#1 hr_n_i = 1'b0;
		repeat (4) @(posedge sys_clk_i);
		#1 hr_n_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		rdsr(8'h05, 8'h00); // Reset pin clears latch.
		chk({quad, hold_f, reset_f, high_frequency_enable}, 4'h4); // Reset reloads stored bits.
		tx(40'h5000000000, 8);
		tx(40'h0100000000, 32);
		chk({quad, hold_f, reset_f, high_frequency_enable}, 4'h4); // Hold function chosen.
	endtask
	task automatic s_susp;
		tx(40'h0600000000, 8);
		tx(40'h02020000A5, 40);
		tx(40'h0600000000, 8);
		tx(40'h7500000000, 8);
		chk({busy, susp}, 2'h1); // Suspend flag set.
		rdsr(8'h35, 8'h80); // Flag readable.
		tx(40'h7A00000000, 8);
		chk(susp, 1'b0); // Resume clears flag.
		wait_idle();
		rdsr(8'h05, 8'h00); // Latch cleared once program ends.
	endtask
	task automatic s_part;
		int c;
		tx(40'h0600000000, 8);
		c = n_ops;
		tx(40'h2003000000, 31);
		chk(n_ops, c); // Partial frame ignored.
		rdsr(8'h05, 8'h02); // Latch still set.
		tx(40'h0400000000, 8);
	endtask
	task automatic s_dpd;
		tx(40'hB900000000, 8);
		chk(deep_pd, 1'b1); // Power-down entered.
		tx(40'h0600000000, 8);
		tx(40'hAB00000000, 8);
		chk(deep_pd, 1'b0); // Release accepted.
		rdsr(8'h05, 8'h00); // Enable ignored.
	endtask
	task automatic s_lock;
		wsr(24'h000100, 24);
		wsr(24'h840000, 16);
		rdsr(8'h05, 8'h02); // Lock-down refuses.
		tx(40'h6600000000, 8);
		tx(40'h9900000000, 8);
		rdsr(8'h35, 8'h00); // Soft reset unlocks.
	endtask
	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		#1 arst_n_i = 1'b1;
		repeat (3) @(posedge sys_clk_i);
		s_powerup();
		s_nv();
		s_prot();
		s_srp();
		s_vol();
		s_susp();
		s_part();
		s_dpd();
		s_lock();
		close_out();
	end
endmodule
`default_nettype wire

// *** rtl/fswp_core.v ***
// Contract
// - Top/bottom bit 0 protects from array top, 1 from bottom; default 0.
// - Granularity bit 1 selects 4-kB sectors, 0 selects 64-kB blocks.
// - Complement bit inverts the protected region chosen by other bits.
// - Protect bits live in SR2 bit 0 and SR1 bit 7, non-volatile.
// - Protect bits 00: pin ignored, status writes allowed when enable latch set.
// - Protect bits 01 with pin low: status registers locked.
// - Protect bits 01 with pin high: writes allowed when enable latch set.
// - Protect bits 10 refuse writes; power cycle or soft reset clears to 00.
// - Protect bits 11 refuse every status write permanently.
// - Busy, enable latch and suspend flag are read-only: status write data never sets them.
// - Protected configuration bits are blocked whenever registers are locked.
// - Write enable then status write updates non-volatile copies.
// - Volatile enable then status write updates volatile copies only.
// - Volatile status write leaves the security lock bits unchanged.
// - Suspend sets suspend flag; resume or power cycle clears it.
// - Lock bits one-time set, default 0; set lock makes register read-only.
// - Quad enable 0 keeps protect and hold/reset pins; 1 makes data lines.
// - With quad off, select bit chooses hold (0) or reset (1) pin.
// - Drive field: 00 50%, 01 25%, 10 75%, 11 100%.
// - Write, program or erase not ending on a byte boundary is ignored.
// - Write-type commands rejected until the power-up write delay elapses.
// - Enable latch 0 at power-up, cleared after program, erase, status write.
// - While busy only status reads and suspend (refused during a status write) are accepted.
// - Program or erase touching any protected part is ignored; block erase checks only from its given address to the block end.
`include "fswp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module fswp_core #(
	parameter [23:0] PUW_CYCLES = `FSWP_PUW_US * `FSWP_CLK_MHZ,
	parameter [23:0] WSR_CYCLES = `FSWP_WSR_US * `FSWP_CLK_MHZ,
	parameter [23:0] PP_CYCLES = `FSWP_PP_US * `FSWP_CLK_MHZ,
	parameter [23:0] ERASE_CYCLES = `FSWP_ERASE_US * `FSWP_CLK_MHZ
) (
	input wire sys_clk_i,
	input wire arst_n_i,
	input wire spi_clk_i,
	input wire cs_n_i,
	input wire mosi_i,
	input wire wp_n_i,
	input wire hold_reset_n_i,
	output reg miso_o,
	output reg miso_oe_o,
	output reg busy_o,
	output reg op_start_o,
	output reg [2:0] op_kind_o,
	output reg [23:0] op_addr_o,
	output wire [2:0] sec_lock_o,
	output wire quad_enable_o,
	output reg hold_func_o,
	output reg reset_func_o,
	output wire [1:0] drive_strength_o,
	output wire high_freq_o,
	output reg deep_pd_o,
	output reg suspended_o
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	reg sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, cs_s3;
	reg mosi_s1, mosi_s2, wp_s1, wp_s2, hr_s1, hr_s2;

	always @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			{sck_s1, sck_s2, sck_s3} <= 3'h0;
			{cs_s1, cs_s2, cs_s3} <= 3'h7;
			{mosi_s1, mosi_s2} <= 2'h0;
			{wp_s1, wp_s2, hr_s1, hr_s2} <= 4'hF;
		end
		else
		begin
			sck_s1 <= spi_clk_i;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			mosi_s1 <= mosi_i;
			mosi_s2 <= mosi_s1;
			wp_s1 <= wp_n_i;
			wp_s2 <= wp_s1;
			hr_s1 <= hold_reset_n_i;
			hr_s2 <= hr_s1;
		end
	end

	// ****************************************
	// Status state
	// ****************************************
	reg [7:0] sr1_v, sr2_v, sr3_v, sr1_n, sr2_n, sr3_n;
	reg write_enable_latch, vwel, busy, suspend_flag, deep_power_down, rsten;
	reg [2:0] op_kind;
	reg [23:0] busy_cnt, puw_cnt;
	reg [7:0] shreg, cmd, b1, b2, b3, tx;
	reg [2:0] bitcnt, bytecnt;
	reg rd_act;

	// The lock bits have no volatile copy, so reads always show the stored value.
	wire [7:0] sr1_rd = {sr1_v[7:2], write_enable_latch, busy};
	wire [7:0] sr2_rd = {suspend_flag, sr2_v[6], sr2_n[5:3], 1'b0, sr2_v[1:0]};
	wire [7:0] sr3_rd = {sr3_v[7:4], 4'h0};

	assign sec_lock_o = sr2_n[`FSWP_SR2_LB];
	assign quad_enable_o = sr2_v[`FSWP_SR2_QE];
	assign drive_strength_o = sr3_v[`FSWP_SR3_DRV];
	assign high_freq_o = sr3_v[`FSWP_SR3_HFM];

	wire qe = sr2_v[`FSWP_SR2_QE];
	wire hold_act = !qe && !sr3_v[`FSWP_SR3_PIN_FUNCTION_SELECT] && !hr_s2;
	wire rst_act = !qe && sr3_v[`FSWP_SR3_PIN_FUNCTION_SELECT] && !hr_s2;
	wire sck_rise = sck_s2 && !sck_s3 && !cs_s2 && !hold_act;
	wire sck_fall = !sck_s2 && sck_s3 && !cs_s2 && !hold_act;
	wire cs_rise = cs_s2 && !cs_s3;
	wire cs_fall = !cs_s2 && cs_s3;
	wire [7:0] in_byte = {shreg[6:0], mosi_s2};
	wire puw_ok = (puw_cnt == 24'h0);

	// ****************************************
	// Protection map
	// ****************************************
	reg [4:0] sh;
	reg [18:0] msk, p_lo, p_hi;
	reg p_none;

	always @*
	begin
		case ({sr1_v[`FSWP_SR1_SEC], sr1_v[`FSWP_SR1_BP]})
			4'h1: sh = 5'h10;
			4'h2: sh = 5'h11;
			4'h3: sh = 5'h12;
			4'h9: sh = 5'h0C;
			4'hA: sh = 5'h0D;
			4'hB: sh = 5'h0E;
			4'hC, 4'hD, 4'hE: sh = 5'h0F;
			default: sh = 5'h13;
		endcase
		msk = ~(`FSWP_ADDR_MAX << sh);
		p_none = (sr1_v[`FSWP_SR1_BP] == 3'h0);
		if (sr1_v[`FSWP_SR1_TB])
		begin
			p_lo = 19'h0;
			p_hi = msk;
		end
		else
		begin
			p_lo = ~msk;
			p_hi = `FSWP_ADDR_MAX;
		end
		if (sr2_v[`FSWP_SR2_CMP])
		begin
			if (p_none)
			begin
				p_none = 1'b0;
				p_lo = 19'h0;
				p_hi = `FSWP_ADDR_MAX;
			end
			else if (msk == `FSWP_ADDR_MAX)
				p_none = 1'b1;
			else if (sr1_v[`FSWP_SR1_TB])
			begin
				p_lo = msk + 19'h1;
				p_hi = `FSWP_ADDR_MAX;
			end
			else
			begin
				p_hi = ~msk - 19'h1;
				p_lo = 19'h0;
			end
		end
	end

	// True when the span s..e touches the protected range.
	function fswp_hit;
		input [18:0] s, e, lo, hi;
		input none;
		begin
			fswp_hit = !none && (s <= hi) && (e >= lo);
		end
	endfunction

	wire [23:0] addr = {b1, b2, b3};
	reg [18:0] span_e;

	always @*
	begin
		span_e = addr[18:0] | `FSWP_BLK_MASK;
		if (cmd == `FSWP_CMD_PP)
			span_e = addr[18:0] | `FSWP_PAGE_MASK;
		else if (cmd == `FSWP_CMD_SE)
			span_e = addr[18:0] | `FSWP_SECT_MASK;
	end

	wire hit = fswp_hit(addr[18:0], span_e, p_lo, p_hi, p_none);
	wire [1:0] srp = {sr2_v[`FSWP_SR2_STATUS_PROTECT_HIGH], sr1_v[`FSWP_SR1_STATUS_PROTECT_LOW]};
	wire sr_open = (srp == 2'h0) || ((srp == 2'h1) && (qe || wp_s2));
	wire frame_ok = cs_rise && (bytecnt != 3'h0) && (bitcnt == 3'h0);
	wire [1:0] sec_idx = addr[13:12];
	wire sec_ok = (sec_idx != 2'h0) && !sr2_n[3 + {1'b0, sec_idx} - 3'h1];

	// ****************************************
	// Serial engine and command execution
	// ****************************************
	always @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sr1_v <= `FSWP_SR1_RST;
			sr2_v <= `FSWP_SR2_RST;
			sr3_v <= `FSWP_SR3_RST;
			sr1_n <= `FSWP_SR1_RST;
			sr2_n <= `FSWP_SR2_RST;
			sr3_n <= `FSWP_SR3_RST;
			{write_enable_latch, vwel, busy, suspend_flag, deep_power_down, rsten, rd_act} <= 7'h0;
			op_kind <= `FSWP_OP_NONE;
			busy_cnt <= 24'h0;
			puw_cnt <= PUW_CYCLES;
			{shreg, cmd, b1, b2, b3, tx} <= 48'h0;
			{bitcnt, bytecnt} <= 6'h0;
			{miso_o, miso_oe_o, busy_o, op_start_o} <= 4'h0;
			op_kind_o <= `FSWP_OP_NONE;
			op_addr_o <= 24'h0;
			{hold_func_o, reset_func_o, deep_pd_o, suspended_o} <= 4'h0;
		end
		else
		begin
			op_start_o <= 1'b0;
			if (!puw_ok)
				puw_cnt <= puw_cnt - 24'h1;
			if (busy)
			begin
				busy_cnt <= busy_cnt - 24'h1;
				if (busy_cnt == 24'h1)
				begin
					busy <= 1'b0;
					write_enable_latch <= 1'b0;
				end
			end
			if (cs_fall)
			begin
				bitcnt <= 3'h0;
				bytecnt <= 3'h0;
			end
			if (sck_rise)
			begin
				shreg <= in_byte;
				bitcnt <= bitcnt + 3'h1;
				if (bitcnt == 3'h7)
				begin
					if (bytecnt != 3'h7)
						bytecnt <= bytecnt + 3'h1;
					case (bytecnt)
						3'h0: cmd <= in_byte;
						3'h1: b1 <= in_byte;
						3'h2: b2 <= in_byte;
						3'h3: b3 <= in_byte;
						default: ;
					endcase
					if (bytecnt == 3'h0 && !deep_power_down)
						rd_act <= (in_byte == `FSWP_CMD_RDSR1) || (in_byte == `FSWP_CMD_RDSR2)
							|| (in_byte == `FSWP_CMD_RDSR3);
					// Reloading each byte lets a polling host watch busy fall live.
					if ((bytecnt == 3'h0 ? in_byte : cmd) == `FSWP_CMD_RDSR2)
						tx <= sr2_rd;
					else if ((bytecnt == 3'h0 ? in_byte : cmd) == `FSWP_CMD_RDSR3)
						tx <= sr3_rd;
					else
						tx <= sr1_rd;
				end
			end
			if (sck_fall && rd_act)
			begin
				miso_o <= tx[7];
				tx <= {tx[6:0], 1'b0};
			end
			if (cs_rise)
				rd_act <= 1'b0;
			if (frame_ok)
			begin
				if (deep_power_down)
				begin
					if (cmd == `FSWP_CMD_RELPD)
						deep_power_down <= 1'b0;
				end
				else if (busy)
				begin
					if (cmd == `FSWP_CMD_SUSP && op_kind != `FSWP_OP_WSR)
					begin
						suspend_flag <= 1'b0 | 1'b1;
						busy <= 1'b0;
					end
				end
				else if (suspend_flag)
				begin
					if (cmd == `FSWP_CMD_RESM)
					begin
						suspend_flag <= 1'b0;
						busy <= 1'b1;
					end
				end
				else
				begin
					rsten <= (cmd == `FSWP_CMD_RSTEN);
					if (cmd == `FSWP_CMD_WREN && puw_ok)
					begin
						write_enable_latch <= 1'b1;
						vwel <= 1'b0;
					end
					else if (cmd == `FSWP_CMD_WRDI)
					begin
						write_enable_latch <= 1'b0;
						vwel <= 1'b0;
					end
					else if (cmd == `FSWP_CMD_VWREN && puw_ok)
						vwel <= 1'b1;
					else if (cmd == `FSWP_CMD_PDOWN)
						deep_power_down <= 1'b1;
					else if (cmd == `FSWP_CMD_RST && rsten)
					begin
						sr1_v <= sr1_n;
						sr2_v <= sr2_n;
						sr3_v <= sr3_n;
						{write_enable_latch, vwel} <= 2'h0;
						if ({sr2_n[0], sr1_n[7]} == 2'h2)
						begin
							sr2_n[0] <= 1'b0;
							sr2_v[0] <= 1'b0;
						end
					end
					else if (cmd == `FSWP_CMD_WRSR && puw_ok && bytecnt >= 3'h2 && sr_open && (write_enable_latch || vwel))
					begin
						vwel <= 1'b0;
						if (write_enable_latch)
						begin
							sr1_n <= (sr1_n & ~`FSWP_SR1_WMASK) | (b1 & `FSWP_SR1_WMASK);
							sr1_v <= (sr1_v & ~`FSWP_SR1_WMASK) | (b1 & `FSWP_SR1_WMASK);
							if (bytecnt >= 3'h3)
							begin
								sr2_n <= (sr2_n & ~`FSWP_SR2_WMASK) | (b2 & `FSWP_SR2_WMASK)
									| (b2 & 8'h38);
								sr2_v <= (sr2_v & ~`FSWP_SR2_WMASK) | (b2 & `FSWP_SR2_WMASK);
							end
							if (bytecnt >= 3'h4)
							begin
								sr3_n <= (sr3_n & ~`FSWP_SR3_NVMASK) | (b3 & `FSWP_SR3_NVMASK);
								sr3_v <= (sr3_v & ~`FSWP_SR3_NVMASK) | (b3 & `FSWP_SR3_NVMASK);
							end
							busy <= 1'b1;
							busy_cnt <= WSR_CYCLES;
							op_kind <= `FSWP_OP_WSR;
						end
						else
						begin
							sr1_v <= (sr1_v & ~`FSWP_SR1_WMASK) | (b1 & `FSWP_SR1_WMASK);
							if (bytecnt >= 3'h3)
								sr2_v <= (sr2_v & ~`FSWP_SR2_WMASK) | (b2 & `FSWP_SR2_WMASK);
							if (bytecnt >= 3'h4)
								sr3_v <= (sr3_v & ~`FSWP_SR3_VMASK) | (b3 & `FSWP_SR3_VMASK);
						end
					end
					else if (write_enable_latch && puw_ok && !hit && ((cmd == `FSWP_CMD_PP && bytecnt >= 3'h5)
						|| ((cmd == `FSWP_CMD_SE || cmd == `FSWP_CMD_BE) && bytecnt == 3'h4)))
					begin
						busy <= 1'b1;
						busy_cnt <= (cmd == `FSWP_CMD_PP) ? PP_CYCLES : ERASE_CYCLES;
						op_kind <= (cmd == `FSWP_CMD_PP) ? `FSWP_OP_PROG :
							(cmd == `FSWP_CMD_SE) ? `FSWP_OP_SERASE : `FSWP_OP_BERASE;
						op_kind_o <= (cmd == `FSWP_CMD_PP) ? `FSWP_OP_PROG :
							(cmd == `FSWP_CMD_SE) ? `FSWP_OP_SERASE : `FSWP_OP_BERASE;
						op_addr_o <= addr;
						op_start_o <= 1'b1;
					end
					else if (write_enable_latch && puw_ok && p_none && bytecnt == 3'h1
						&& (cmd == `FSWP_CMD_CE || cmd == `FSWP_CMD_CE2))
					begin
						busy <= 1'b1;
						busy_cnt <= ERASE_CYCLES;
						op_kind <= `FSWP_OP_CERASE;
						op_kind_o <= `FSWP_OP_CERASE;
						op_addr_o <= 24'h0;
						op_start_o <= 1'b1;
					end
					else if (write_enable_latch && puw_ok && sec_ok && ((cmd == `FSWP_CMD_SECPP && bytecnt >= 3'h5)
						|| (cmd == `FSWP_CMD_SECER && bytecnt == 3'h4)))
					begin
						busy <= 1'b1;
						busy_cnt <= (cmd == `FSWP_CMD_SECPP) ? PP_CYCLES : ERASE_CYCLES;
						op_kind <= (cmd == `FSWP_CMD_SECPP) ? `FSWP_OP_SECPROG : `FSWP_OP_SECERASE;
						op_kind_o <= (cmd == `FSWP_CMD_SECPP) ? `FSWP_OP_SECPROG : `FSWP_OP_SECERASE;
						op_addr_o <= addr;
						op_start_o <= 1'b1;
					end
				end
			end
			// Reset pin acts as soft reset
			if (rst_act)
			begin
				sr1_v <= sr1_n;
				sr2_v <= sr2_n;
				sr3_v <= sr3_n;
				{write_enable_latch, vwel, suspend_flag, busy, rsten, rd_act} <= 6'h0;
				bytecnt <= 3'h0;
				bitcnt <= 3'h0;
			end
			miso_oe_o <= rd_act && !cs_s2;
			busy_o <= busy;
			hold_func_o <= !qe && !sr3_v[`FSWP_SR3_PIN_FUNCTION_SELECT];
			reset_func_o <= !qe && sr3_v[`FSWP_SR3_PIN_FUNCTION_SELECT];
			deep_pd_o <= deep_power_down;
			suspended_o <= suspend_flag;
		end
	end

endmodule

`default_nettype wire

// *** rtl/fswp_defs.vh ***
`ifndef FSWP_DEFS_VH
`define FSWP_DEFS_VH

// ****************************************
// Serial commands
// ****************************************
`define FSWP_CMD_WREN 8'h06
`define FSWP_CMD_WRDI 8'h04
`define FSWP_CMD_VWREN 8'h50
`define FSWP_CMD_WRSR 8'h01
`define FSWP_CMD_RDSR1 8'h05
`define FSWP_CMD_RDSR2 8'h35
`define FSWP_CMD_RDSR3 8'h15
`define FSWP_CMD_SUSP 8'h75
`define FSWP_CMD_RESM 8'h7A
`define FSWP_CMD_PDOWN 8'hB9
`define FSWP_CMD_RELPD 8'hAB
`define FSWP_CMD_PP 8'h02
`define FSWP_CMD_SE 8'h20
`define FSWP_CMD_BE 8'hD8
`define FSWP_CMD_CE 8'hC7
`define FSWP_CMD_CE2 8'h60
`define FSWP_CMD_SECPP 8'h42
`define FSWP_CMD_SECER 8'h44
`define FSWP_CMD_RSTEN 8'h66
`define FSWP_CMD_RST 8'h99

// ****************************************
// Status register fields
// ****************************************
`define FSWP_SR1_STATUS_PROTECT_LOW 7
`define FSWP_SR1_SEC 6
`define FSWP_SR1_TB 5
`define FSWP_SR1_BP 4:2
`define FSWP_SR2_CMP 6
`define FSWP_SR2_LB 5:3
`define FSWP_SR2_QE 1
`define FSWP_SR2_STATUS_PROTECT_HIGH 0
`define FSWP_SR3_PIN_FUNCTION_SELECT 7
`define FSWP_SR3_DRV 6:5
`define FSWP_SR3_HFM 4
`define FSWP_SR1_WMASK 8'hFC
`define FSWP_SR2_WMASK 8'h43
`define FSWP_SR3_NVMASK 8'h90
`define FSWP_SR3_VMASK 8'hF0
`define FSWP_SR1_RST 8'h00
`define FSWP_SR2_RST 8'h00
`define FSWP_SR3_RST 8'h00

// ****************************************
// Array and operation kinds
// ****************************************
`define FSWP_AW 19
`define FSWP_ADDR_MAX 19'h7FFFF
`define FSWP_PAGE_MASK 19'h000FF
`define FSWP_SECT_MASK 19'h00FFF
`define FSWP_BLK_MASK 19'h0FFFF
`define FSWP_OP_NONE 3'h0
`define FSWP_OP_PROG 3'h1
`define FSWP_OP_SERASE 3'h2
`define FSWP_OP_BERASE 3'h3
`define FSWP_OP_CERASE 3'h4
`define FSWP_OP_SECPROG 3'h5
`define FSWP_OP_SECERASE 3'h6
`define FSWP_OP_WSR 3'h7

// ****************************************
// Timing
// ****************************************
`define FSWP_CLK_MHZ 200
`define FSWP_PUW_US 1000
`define FSWP_WSR_US 100
`define FSWP_PP_US 500
`define FSWP_ERASE_US 1000
`define FSWP_CNT_W 24

`endif

// *** rtl/fswp_unused_placeholder_removed.v ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
